// ---- rtl/fcl_loader.sv ----
// Local design decision: register access over Wishbone.
`timescale 1ns/10ps
module fcl_loader #(
   parameter int ADDR_W = 14,
   parameter int MS_CYCLES = fcl_pkg::CYC_PER_MS
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic por_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Fuse array
   output logic [3:0] fuse_addr_o,
   input wire logic [7:0] fuse_data_i,
   // CRC engine handshake
   output logic crc_boot_start_o,
   output logic crc_app_start_o,
   input wire logic crc_done_i,
   // System outputs
   output logic sys_reset_o,
   output logic [7:0] fault_control_reg_o,
   output logic [3:0] cmp_pin_enable_o,
   output logic [3:0] cmp_default_level_o,
   output logic [1:0] reset_pin_function_o,
   output logic chip_erase_eeprom_o,
   output logic dbg_bus_allow_o,
   // Debug access and flash classify
   input wire logic dbg_cs_space_i,
   input wire logic [ADDR_W-1:0] flash_addr_i,
   output logic in_boot_o,
   output logic in_app_o,
   output logic in_data_o
);
   fcl_nvm_if nvm ();
   fcl_pkg::fcl_state_t state_reg, state_next;
   logic [7:0] fuse_reg [0:fcl_pkg::FUSE_COUNT-1];
   logic [3:0] idx_reg;
   logic [31:0] cnt_reg;
   logic por_seen_reg;
   logic [7:0] lock_reg;
   logic lock_wr;
   logic ack_reg;
   logic [31:0] rd_reg;
   logic crc_req_reg;

   fcl_nvm_port u_port (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .nvm(nvm),
      .fuse_addr_o(fuse_addr_o),
      .fuse_data_i(fuse_data_i)
   );

   fcl_region #(.ADDR_W(ADDR_W)) u_region (
      .boot_end_i(fuse_reg[fcl_pkg::OFS_BOOT_END]),
      .app_end_i(fuse_reg[fcl_pkg::OFS_APP_END]),
      .addr_i(flash_addr_i),
      .in_boot_o(in_boot_o),
      .in_app_o(in_app_o),
      .in_data_o(in_data_o)
   );

   wire [7:0] sys0 = fuse_reg[fcl_pkg::OFS_SYS0];
   wire [2:0] startup_delay_sel = fuse_reg[fcl_pkg::OFS_SYS1][2:0];
   wire [31:0] delay_cycles = (startup_delay_sel == 3'h0) ? 32'h0 :
                              (32'(MS_CYCLES) << (startup_delay_sel - 3'h1));
   wire boot_crc_on = ~sys0[fcl_pkg::BIT_BOOT_CRC_DIS];
   wire app_crc_on = ~sys0[fcl_pkg::BIT_APP_CRC_DIS];
   wire locked = (lock_reg != fcl_pkg::LOCK_OPEN);
   wire loading = (state_reg == fcl_pkg::FCL_READ);
   wire byte_in = loading & nvm.valid;
   wire last_byte = byte_in & (idx_reg == fcl_pkg::LAST_FUSE);
   wire crc_state = (state_reg == fcl_pkg::FCL_CRC_BOOT) || (state_reg == fcl_pkg::FCL_CRC_APP);
   wire crc_end = crc_state & crc_req_reg & crc_done_i;

   assign nvm.req = loading & ~nvm.valid;
   assign nvm.addr = idx_reg;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         fcl_pkg::FCL_POR_IDLE: state_next = fcl_pkg::FCL_READ;
         fcl_pkg::FCL_READ: begin
            if (last_byte) begin
               state_next = fcl_pkg::FCL_CRC_BOOT;
            end
         end
         fcl_pkg::FCL_CRC_BOOT: begin
            if (!boot_crc_on || crc_end) begin
               state_next = fcl_pkg::FCL_CRC_APP;
            end
         end
         fcl_pkg::FCL_CRC_APP: begin
            if (!app_crc_on || crc_end) begin
               state_next = fcl_pkg::FCL_DELAY;
            end
         end
         fcl_pkg::FCL_DELAY: begin
            if (cnt_reg >= delay_cycles) begin
               state_next = fcl_pkg::FCL_RUN;
            end
         end
         fcl_pkg::FCL_RUN: state_next = fcl_pkg::FCL_RUN;
         default: state_next = fcl_pkg::FCL_POR_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= fcl_pkg::FCL_POR_IDLE;
         idx_reg <= 4'h0;
         cnt_reg <= 32'h0;
         crc_req_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (byte_in) begin
            idx_reg <= idx_reg + 4'h1;
         end
         cnt_reg <= (state_reg == fcl_pkg::FCL_DELAY) ? cnt_reg + 32'h1 : 32'h0;
         crc_req_reg <= crc_state & (state_next == state_reg);
      end
   end

   // Fuse shadow; one write per byte during the read phase
   genvar gi;
   generate
      for (gi = 0; gi < fcl_pkg::FUSE_COUNT; gi++) begin : g_fuse
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               fuse_reg[gi] <= (gi == fcl_pkg::OFS_SYS0) ? fcl_pkg::RST_SYS0 :
                               (gi == fcl_pkg::OFS_SYS1) ? fcl_pkg::RST_SYS1 : fcl_pkg::RST_ZERO;
            end else if (byte_in && idx_reg == 4'(gi)) begin
               fuse_reg[gi] <= nvm.data;
            end
         end
      end
   endgenerate

   // Timer settings survive non power-on resets, so they sit outside rst_i
   always_ff @(posedge clk_i) begin
      if (por_i) begin
         por_seen_reg <= 1'b1;
         fault_control_reg_o <= 8'h00;
      end else if (por_seen_reg && state_reg == fcl_pkg::FCL_CRC_BOOT) begin
         por_seen_reg <= 1'b0;
         fault_control_reg_o <= fuse_reg[fcl_pkg::OFS_TIMER];
      end
   end
   assign cmp_pin_enable_o = fault_control_reg_o[7:fcl_pkg::BIT_CMP_EN_LO];
   assign cmp_default_level_o = fault_control_reg_o[fcl_pkg::BIT_CMP_EN_LO-1:0];

   // Lock byte: loaded from fuse, then software writable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_reg <= 8'h00;
      end else if (byte_in && idx_reg == fcl_pkg::OFS_LOCK) begin
         lock_reg <= nvm.data;
      end else if (lock_wr) begin
         lock_reg <= wb_dat_i[7:0];
      end
   end

   wire wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
   wire [3:0] wb_idx = wb_adr_i[5:2];
   assign lock_wr = wb_req & wb_we_i & wb_sel_i[0] & (wb_idx == fcl_pkg::OFS_LOCK);
   wire [7:0] status = {2'h0, state_reg, locked, crc_state, sys_reset_o};
   wire [7:0] rd_byte = (wb_idx <= fcl_pkg::LAST_FUSE && wb_idx != fcl_pkg::OFS_LOCK) ? fuse_reg[wb_idx] :
                        (wb_idx == fcl_pkg::OFS_LOCK) ? lock_reg :
                        (wb_idx == fcl_pkg::OFS_STATUS) ? status : 8'h00;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         rd_reg <= 32'h0;
      end else begin
         ack_reg <= wb_req;
         rd_reg <= {24'h0, rd_byte};
      end
   end
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rd_reg;

   assign sys_reset_o = (state_reg != fcl_pkg::FCL_RUN);
   assign crc_boot_start_o = (state_reg == fcl_pkg::FCL_CRC_BOOT) & boot_crc_on & ~crc_req_reg;
   assign crc_app_start_o = (state_reg == fcl_pkg::FCL_CRC_APP) & app_crc_on & ~crc_req_reg;
   assign reset_pin_function_o = sys0[fcl_pkg::BIT_RST_PIN_LO+1:fcl_pkg::BIT_RST_PIN_LO];
   assign chip_erase_eeprom_o = locked | ~sys0[fcl_pkg::BIT_EE_PRESERVE];
   assign dbg_bus_allow_o = ~locked | dbg_cs_space_i;
endmodule

// ---- rtl/fcl_nvm_if.sv ----
`timescale 1ns/10ps
interface fcl_nvm_if;
   logic req;
   logic [3:0] addr;
   logic [7:0] data;
   logic valid;
   modport loader (output req, output addr, input data, input valid);
   modport port (input req, input addr, output data, output valid);
endinterface

// ---- rtl/fcl_nvm_port.sv ----
`timescale 1ns/10ps
// One-cycle registered read of the external fuse array
module fcl_nvm_port (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Loader side
   fcl_nvm_if.port nvm,
   // Fuse array pins
   output logic [3:0] fuse_addr_o,
   input wire logic [7:0] fuse_data_i
);
   logic valid_reg;
   logic [7:0] data_reg;
   assign fuse_addr_o = nvm.addr;
   assign nvm.data = data_reg;
   assign nvm.valid = valid_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         valid_reg <= 1'b0;
         data_reg <= 8'h00;
      end else begin
         valid_reg <= nvm.req & ~valid_reg;
         data_reg <= fuse_data_i;
      end
   end
endmodule

// ---- rtl/fcl_pkg.sv ----
package fcl_pkg;
   localparam int FUSE_COUNT = 11;
   localparam logic [3:0] OFS_TIMER = 4'h4;
   localparam logic [3:0] OFS_SYS0 = 4'h5;
   localparam logic [3:0] OFS_SYS1 = 4'h6;
   localparam logic [3:0] OFS_APP_END = 4'h7;
   localparam logic [3:0] OFS_BOOT_END = 4'h8;
   localparam logic [3:0] OFS_LOCK = 4'hA;
   localparam logic [3:0] OFS_STATUS = 4'hC;
   localparam logic [3:0] OFS_CTRL = 4'hD;
   localparam logic [3:0] LAST_FUSE = 4'hA;
   localparam int BIT_BOOT_CRC_DIS = 7;
   localparam int BIT_APP_CRC_DIS = 6;
   localparam int BIT_RST_PIN_LO = 2;
   localparam int BIT_EE_PRESERVE = 0;
   localparam int BIT_CMP_EN_LO = 4;
   localparam logic [7:0] LOCK_OPEN = 8'hC5;
   localparam logic [7:0] RST_SYS0 = 8'hF6;
   localparam logic [7:0] RST_SYS1 = 8'h07;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [1:0] PIN_GPIO = 2'h0;
   localparam logic [1:0] PIN_RESET = 2'h1;
   localparam logic [1:0] PIN_DEBUG = 2'h2;
   localparam logic [1:0] PIN_DEBUG_ALT = 2'h3;
   localparam int BLOCK_SHIFT = 8;
   localparam int CLK_HZ = 100000000;
   localparam int UNIT_MS = 1;
   localparam int CYC_PER_MS = CLK_HZ / 1000 * UNIT_MS;
   localparam int CRC_CYCLES = 16;
   typedef enum logic [2:0] {
      FCL_POR_IDLE = 3'b000,
      FCL_READ = 3'b001,
      FCL_CRC_BOOT = 3'b011,
      FCL_CRC_APP = 3'b010,
      FCL_DELAY = 3'b110,
      FCL_RUN = 3'b111
   } fcl_state_t;
endpackage

// ---- rtl/fcl_region.sv ----
`timescale 1ns/10ps
// Flash section classifier for one address
module fcl_region #(
   parameter int ADDR_W = 14
) (
   // Section ends
   input wire logic [7:0] boot_end_i,
   input wire logic [7:0] app_end_i,
   input wire logic [ADDR_W-1:0] addr_i,
   // Classification
   output logic in_boot_o,
   output logic in_app_o,
   output logic in_data_o
);
   wire [ADDR_W-1:0] page = addr_i >> fcl_pkg::BLOCK_SHIFT;
   wire all_boot = (boot_end_i == 8'h00);
   wire boot_hit = all_boot || (page < {{(ADDR_W-8){1'b0}}, boot_end_i});
   wire app_top = (app_end_i == 8'h00) || (page < {{(ADDR_W-8){1'b0}}, app_end_i});
   assign in_boot_o = boot_hit;
   assign in_app_o = ~boot_hit & app_top;
   assign in_data_o = ~boot_hit & ~app_top;
endmodule

// ---- verif/fcl_fuse_model.sv ----
`timescale 1ns/10ps
// Fuse array plus CRC engine; the CRC answers after crc_wait_i cycles
module fcl_fuse_model (
   // Clock
   input wire logic clk_i,
   // Fuse array
   input wire logic [3:0] fuse_addr_i,
   output logic [7:0] fuse_data_o,
   // CRC engine
   input wire logic boot_i,
   input wire logic app_i,
   input wire logic [3:0] crc_wait_i,
   output logic done_o
);
   logic [7:0] fuse [16];
   logic [3:0] cnt_reg = 4'h0;
   logic prev_reg = 1'b0;
   logic start;
   int n_boot = 0;
   int n_app = 0;
   assign fuse_data_o = fuse[fuse_addr_i];
   // Start may stay high, so only its rising edge opens a check
   assign start = (boot_i || app_i) && !prev_reg;
   initial done_o = 1'b0;
   always @(posedge clk_i) begin
      prev_reg <= boot_i || app_i;
      done_o <= cnt_reg == 4'h1;
      if (start)
         cnt_reg <= crc_wait_i;
      else if (cnt_reg != 4'h0)
         cnt_reg <= cnt_reg - 4'h1;
      if (start && boot_i)
         n_boot <= n_boot + 1;
      if (start && app_i)
         n_app <= n_app + 1;
   end
endmodule

// ---- verif/fcl_loader_assertions.sv ----
`timescale 1ns/10ps
module fcl_loader_assertions (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Watched ports
   input wire logic sys_reset_o,
   input wire logic crc_boot_start_o,
   input wire logic crc_app_start_o,
   input wire logic [7:0] fault_control_reg_o,
   input wire logic [3:0] cmp_pin_enable_o,
   input wire logic [3:0] cmp_default_level_o,
   input wire logic chip_erase_eeprom_o,
   input wire logic dbg_bus_allow_o,
   input wire logic dbg_cs_space_i,
   input wire logic in_boot_o,
   input wire logic in_app_o,
   input wire logic in_data_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_pin_enable_map: assert property (cmp_pin_enable_o == fault_control_reg_o[7:4])
      else $error("pin enables differ from timer fuse");
   a_level_map: assert property (cmp_default_level_o == fault_control_reg_o[3:0])
      else $error("default levels differ from timer fuse");
   a_lock_erase: assert property (!dbg_bus_allow_o |-> chip_erase_eeprom_o)
      else $error("locked part keeps eeprom");
   a_cs_reach: assert property (dbg_cs_space_i |-> dbg_bus_allow_o)
      else $error("debug own space refused");
   a_region_one: assert property ($onehot({in_boot_o, in_app_o, in_data_o}))
      else $error("flash section not unique");
   a_boot_crc_held: assert property (crc_boot_start_o |-> sys_reset_o)
      else $error("boot check outside reset");
   a_app_crc_held: assert property (crc_app_start_o |-> sys_reset_o)
      else $error("app check outside reset");
   a_load_hold: assert property ($fell(rst_i) |-> sys_reset_o [*8])
      else $error("reset dropped before load");
   a_timer_frozen: assert property ($changed(fault_control_reg_o) |-> sys_reset_o)
      else $error("timer setting changed while running");
   c_released: cover property ($fell(sys_reset_o));
   c_boot_crc: cover property (crc_boot_start_o);
   c_locked: cover property (!dbg_bus_allow_o);
endmodule
bind fcl_loader fcl_loader_assertions chk (.clk_i, .rst_i, .sys_reset_o, .crc_boot_start_o, .crc_app_start_o,
   .fault_control_reg_o, .cmp_pin_enable_o, .cmp_default_level_o, .chip_erase_eeprom_o, .dbg_bus_allow_o,
   .dbg_cs_space_i, .in_boot_o, .in_app_o, .in_data_o);

// ---- verif/test_fcl_loader.sv ----
`timescale 1ns/10ps
module test_fcl_loader;
   localparam int MS = 10;
   logic clk_i, rst_i, por_i, wb_cyc, wb_stb, wb_we, wb_ack, crc_done, dbg_cs, boot_go, app_go, sys_rst;
   logic erase, allow, in_boot, in_app, in_data;
   logic [5:0] wb_adr;
   logic [31:0] wb_wdat, wb_rdat, rd;
   logic [7:0] fault, fuse_data;
   logic [3:0] fuse_addr, pin_en, def_lvl, crc_wait;
   logic [1:0] pin_fn;
   logic [13:0] flash_addr;
   int num_errors = 0;
   int n_tests = 0;
   int cyc_n;
   fcl_loader #(.ADDR_W(14), .MS_CYCLES(MS)) uut (.clk_i, .rst_i, .por_i, .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
      .wb_ack_o(wb_ack), .fuse_addr_o(fuse_addr), .fuse_data_i(fuse_data), .crc_boot_start_o(boot_go),
      .crc_app_start_o(app_go), .crc_done_i(crc_done), .sys_reset_o(sys_rst), .fault_control_reg_o(fault),
      .cmp_pin_enable_o(pin_en), .cmp_default_level_o(def_lvl), .reset_pin_function_o(pin_fn),
      .chip_erase_eeprom_o(erase), .dbg_bus_allow_o(allow), .dbg_cs_space_i(dbg_cs),
      .flash_addr_i(flash_addr), .in_boot_o(in_boot), .in_app_o(in_app), .in_data_o(in_data));
   fcl_fuse_model nvm (.clk_i, .fuse_addr_i(fuse_addr), .fuse_data_o(fuse_data), .boot_i(boot_go),
      .app_i(app_go), .crc_wait_i(crc_wait), .done_o(crc_done));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      if (num_errors == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
      int i;
      i = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_wdat <= d;
      @(posedge clk_i);
      while (!wb_ack && i < 20) begin
         i++;
         @(posedge clk_i);
      end
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (!wb_ack) begin
         num_errors++;
         complete_run;
      end
      @(posedge clk_i);
   endtask
   task automatic boot(input logic p, input logic [7:0] t, s0, s1, ap, be);
      nvm.fuse[4] = t;
      nvm.fuse[5] = s0;
      nvm.fuse[6] = s1;
      nvm.fuse[7] = ap;
      nvm.fuse[8] = be;
      rst_i <= 1'b1;
      por_i <= p;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      por_i <= 1'b0;
      cyc_n = 0;
      @(posedge clk_i);
      while (sys_rst && cyc_n < 3000) begin
         cyc_n++;
         @(posedge clk_i);
      end
      if (sys_rst) begin
         num_errors++;
         complete_run;
      end
   endtask
   task automatic area(input logic [13:0] a, input logic [2:0] exp);
      flash_addr <= a;
      @(posedge clk_i);
      check({in_boot, in_app, in_data}, exp);
   endtask
   task automatic s_power;
      boot(1, 8'h5A, 8'h09, 8'h02, 8'h20, 8'h10);
      check(nvm.n_boot, 1);
      check(nvm.n_app, 1);
      check(fault, 8'h5A);
      check(pin_en, 4'h5);
      check(def_lvl, 4'hA);
      check(erase, 1'b0);
      check(allow, 1'b1);
      for (int k = 4; k < 12; k++) begin
         wb(0, 6'(k * 4), 32'h0);
         check(rd, {24'h0, nvm.fuse[k]});
      end
   endtask
   task automatic s_retain;
      crc_wait = 4'h2;
      boot(0, 8'hA5, 8'h09, 8'h00, 8'h20, 8'h10);
      check(fault, 8'h5A);
      boot(1, 8'hA5, 8'h09, 8'h00, 8'h20, 8'h10);
      check(fault, 8'hA5);
   endtask
   task automatic s_lock;
      wb(1, 6'h28, 32'h0);
      check(allow, 1'b0);
      check(erase, 1'b1);
      dbg_cs <= 1'b1;
      @(posedge clk_i);
      check(allow, 1'b1);
      dbg_cs <= 1'b0;
      wb(1, 6'h10, 32'hFF);
      wb(0, 6'h10, 32'h0);
      check(rd, 32'hA5);
      wb(1, 6'h28, 32'hC5);
      check(allow, 1'b1);
      check(erase, 1'b0);
   endtask
   task automatic s_sut;
      int base;
      base = 0;
      for (int c = 0; c < 8; c++) begin
         boot(0, 8'h00, {4'hC, c[1:0], 2'h0}, 8'(c), 8'h20, 8'h10);
         if (c == 0)
            base = cyc_n;
         else
            check(cyc_n - base, MS << (c - 1));
         check(pin_fn, c[1:0]);
      end
      check(nvm.n_boot + nvm.n_app, 6);
   endtask
   task automatic s_region;
      area(14'h0FFF, 3'b100);
      area(14'h1000, 3'b010);
      area(14'h2000, 3'b001);
      boot(0, 8'h00, 8'hC0, 8'h00, 8'h00, 8'h10);
      area(14'h3FFF, 3'b010);
      boot(0, 8'h00, 8'hC0, 8'h00, 8'h20, 8'h00);
      area(14'h3FFF, 3'b100);
      boot(0, 8'h00, 8'hC0, 8'h00, 8'h00, 8'h00);
      area(14'h2000, 3'b100);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      rst_i = 1'b1;
      por_i = 1'b1;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 6'h00;
      wb_wdat = 32'h0;
      dbg_cs = 1'b0;
      flash_addr = 14'h0000;
      crc_wait = 4'h9;
      for (int k = 0; k < 16; k++)
         nvm.fuse[k] = 8'h00;
      nvm.fuse[10] = 8'hC5;
      s_power;
      s_retain;
      s_lock;
      s_sut;
      s_region;
      complete_run;
   end
endmodule
